// ---- rtl/lcsel_pkg.sv ----
// Shared constants and types for the latched channel select host controller.
`default_nettype none
package lcsel_pkg;
  localparam int unsigned LCSEL_CLK_HZ = 50_000_000;
  localparam int unsigned LCSEL_CLK_NS = 20;
  // Least write pulse width and address setup before the strobe falls, in ns.
  localparam int unsigned LCSEL_WR_PULSE_NS = 300;
  localparam int unsigned LCSEL_SETUP_NS = 180;
  // Cycle counts, least times rounded up.
  localparam int unsigned LCSEL_WR_PULSE_CYC =
    (LCSEL_WR_PULSE_NS + LCSEL_CLK_NS - 1) / LCSEL_CLK_NS;
  localparam int unsigned LCSEL_SETUP_CYC = (LCSEL_SETUP_NS + LCSEL_CLK_NS - 1) / LCSEL_CLK_NS;
  localparam int unsigned LCSEL_CNT_W = 5;
  localparam int unsigned LCSEL_CHAN_W = 3;
  localparam int unsigned LCSEL_CHAR_W = 8;
  // Printable digit characters start at this code; the low bits carry the channel.
  localparam logic [LCSEL_CHAR_W-1:0] LCSEL_DIGIT_ZERO = 8'h30;
  typedef enum logic [2:0] {LCSEL_IDLE, LCSEL_SETUP, LCSEL_PULSE, LCSEL_HOLD} lcsel_state_e;
endpackage
`default_nettype wire

// ---- rtl/lcsel_strobe_if.sv ----
// Interface carrying one strobe request and its completion between the modules.
`default_nettype none
interface lcsel_strobe_if;
  logic start;
  logic busy;
  logic done;
  logic strobe_n;
  modport ctrl (output start, input busy, input done, input strobe_n);
  modport tmr (input start, output busy, output done, output strobe_n);
endinterface
`default_nettype wire

// ---- rtl/lcsel_strobe_timer.sv ----
// Timer that shapes one active-low strobe with setup before it and a least width.
`default_nettype none
module lcsel_strobe_timer
  import lcsel_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  lcsel_strobe_if.tmr sif
);
  lcsel_state_e state_r, state_nxt;
  logic [LCSEL_CNT_W-1:0] cnt_r, cnt_nxt;
  logic strobe_n_r, strobe_n_nxt;
  logic done_r, done_nxt;

  // Next state: setup with strobe high, then a low pulse, then one cycle of hold.
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    strobe_n_nxt = strobe_n_r;
    done_nxt = 1'b0;
    case (state_r)
      LCSEL_IDLE: begin
        if (sif.start) begin
          state_nxt = LCSEL_SETUP;
          cnt_nxt = LCSEL_CNT_W'(LCSEL_SETUP_CYC - 1);
        end
      end
      LCSEL_SETUP: begin
        if (cnt_r == '0) begin
          state_nxt = LCSEL_PULSE;
          strobe_n_nxt = 1'b0;
          cnt_nxt = LCSEL_CNT_W'(LCSEL_WR_PULSE_CYC - 1);
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      LCSEL_PULSE: begin
        if (cnt_r == '0) begin
          state_nxt = LCSEL_HOLD;
          strobe_n_nxt = 1'b1;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      default: begin
        state_nxt = LCSEL_IDLE;
        done_nxt = 1'b1;
      end
    endcase
  end

  // Registers only.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= LCSEL_IDLE;
      cnt_r <= '0;
      strobe_n_r <= 1'b1;
      done_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      strobe_n_r <= strobe_n_nxt;
      done_r <= done_nxt;
    end
  end

  assign sif.strobe_n = strobe_n_r;
  assign sif.done = done_r;
  assign sif.busy = (state_r != LCSEL_IDLE);

  // Last cycle of the low pulse, counted from the first low sample.
  localparam int PULSE_LAST = LCSEL_WR_PULSE_CYC - 1;

  // Once low, the strobe is still low at the last pulse cycle and high on the next one.
  property p_pulse_width;
    @(posedge clk) disable iff (sys_rst)
      $fell(strobe_n_r) |-> ##PULSE_LAST !strobe_n_r ##1 strobe_n_r;
  endproperty
  a_pulse_width: assert property (p_pulse_width) else $error("strobe width wrong");
endmodule
`default_nettype wire

// ---- rtl/lcsel_host.sv ----
// Host controller that selects one of eight channels on a latched selector.
`default_nettype none
// Notes on behaviour
// - Data valid out mirrors the write strobe and data accepted is tied low, so no handshake wait occurs.
// - The host sends one character per channel select transfer.
// - The host sends no trailing end-of-data character.
// - The host sends no decimal point or other non-digit character.
// - The host holds clear low during power up.
// - The host reset drives the selector clear through a register that releases it on the first edge after reset.
// - The host makes the write strobe only while the selector is addressed.
module lcsel_host
  import lcsel_pkg::*;
#(
  parameter int unsigned CHAN_W = LCSEL_CHAN_W
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic req_valid,
  input wire logic [CHAN_W-1:0] req_chan,
  input wire logic req_enable,
  output logic req_ready,
  output logic req_done,
  output logic [LCSEL_CHAR_W-1:0] character_bus,
  output logic host_data_valid_out,
  output logic host_data_accepted_in,
  output logic [CHAN_W-1:0] sel_addr,
  output logic sel_enable,
  output logic sel_wr_n,
  output logic clear_n
);
  lcsel_strobe_if sif ();
  lcsel_strobe_timer u_timer (.clk(clk), .sys_rst(sys_rst), .sif(sif));

  // Cycle distances that the checks below count in plain delays.
  localparam int PULSE_LAST = LCSEL_WR_PULSE_CYC - 1;
  localparam int SETUP_PAST = LCSEL_SETUP_CYC + 1;

  logic [LCSEL_CHAR_W-1:0] char_r, char_nxt;
  logic [CHAN_W-1:0] addr_r, addr_nxt;
  logic en_r, en_nxt;
  logic start_r, start_nxt;
  logic clear_n_r, clear_n_nxt;
  logic done_r, done_nxt;
  logic ready_r, ready_nxt;

  // Forms the single ASCII digit for a channel.
  function automatic logic [LCSEL_CHAR_W-1:0] digit_of(input logic [CHAN_W-1:0] ch);
    digit_of = LCSEL_DIGIT_ZERO | LCSEL_CHAR_W'(ch);
  endfunction

  // Accept one request at a time and present address and character before the strobe.
  always_comb begin
    char_nxt = char_r;
    addr_nxt = addr_r;
    en_nxt = en_r;
    start_nxt = 1'b0;
    clear_n_nxt = 1'b1;
    done_nxt = sif.done;
    ready_nxt = 1'b0;
    if (req_valid && ready_r) begin
      char_nxt = digit_of(req_chan);
      addr_nxt = req_chan;
      en_nxt = req_enable;
      start_nxt = 1'b1;
    end else begin
      ready_nxt = !sif.busy && !start_r && !sif.done && clear_n_r;
    end
  end

  // Registers only; reset holds the selector cleared until the first edge after release.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      char_r <= '0;
      addr_r <= '0;
      en_r <= 1'b0;
      start_r <= 1'b0;
      clear_n_r <= 1'b0;
      done_r <= 1'b0;
      ready_r <= 1'b0;
    end else begin
      char_r <= char_nxt;
      addr_r <= addr_nxt;
      en_r <= en_nxt;
      start_r <= start_nxt;
      clear_n_r <= clear_n_nxt;
      done_r <= done_nxt;
      ready_r <= ready_nxt;
    end
  end

  // Every output but the tied-low host_data_accepted_in is taken straight from a register here or in the timer.
  assign sif.start = start_r;
  assign req_ready = ready_r;
  assign req_done = done_r;
  assign character_bus = char_r;
  assign host_data_valid_out = sif.strobe_n; // Mirrors strobe timing, active low.
  assign host_data_accepted_in = 1'b0;
  assign sel_addr = addr_r;
  assign sel_enable = en_r;
  assign sel_wr_n = sif.strobe_n;
  assign clear_n = clear_n_r;

  // Clear is still low at the first edge after reset and high on the next.
  property p_clear_at_reset;
    @(posedge clk) $fell(sys_rst) |-> !clear_n ##1 clear_n;
  endproperty
  a_clear_at_reset: assert property (p_clear_at_reset) else $error("clear not released");

  // The acknowledge line is never raised, so no transfer waits for it.
  property p_dac_low;
    @(posedge clk) disable iff (sys_rst) !host_data_accepted_in;
  endproperty
  a_dac_low: assert property (p_dac_low) else $error("data accepted not low");

  // Address and enable do not move while the selector latches are open.
  property p_addr_stable;
    @(posedge clk) disable iff (sys_rst) !sel_wr_n |-> $stable(sel_addr) && $stable(sel_enable);
  endproperty
  a_addr_stable: assert property (p_addr_stable) else $error("address moved");

  // Address and enable already stood for the whole setup time when the strobe falls.
  property p_setup;
    @(posedge clk) disable iff (sys_rst) $fell(sel_wr_n) |->
      sel_addr == $past(sel_addr, LCSEL_SETUP_CYC) &&
      sel_enable == $past(sel_enable, LCSEL_SETUP_CYC);
  endproperty
  a_setup: assert property (p_setup) else $error("setup too short");

  // The character shown while data valid is active is the digit of the address.
  property p_digit;
    @(posedge clk) disable iff (sys_rst)
      !sel_wr_n |-> character_bus == {5'h06, sel_addr};
  endproperty
  a_digit: assert property (p_digit) else $error("non-digit character");

  // A strobe is low at its first and last pulse cycle, then high; done follows two cycles
  // later for exactly one cycle, since the timer's done crosses one more register here.
  sequence s_strobe;
    !sel_wr_n ##PULSE_LAST !sel_wr_n ##1 sel_wr_n;
  endsequence
  sequence s_done_pulse;
    req_done ##1 !req_done;
  endsequence
  property p_done;
    @(posedge clk) disable iff (sys_rst) $fell(sel_wr_n) |-> s_strobe ##2 s_done_pulse;
  endproperty
  a_done: assert property (p_done) else $error("done missing");

  // A taken request drops ready at once, so no second one is taken behind it.
  property p_single;
    @(posedge clk) disable iff (sys_rst) start_r |-> !ready_r;
  endproperty
  a_single: assert property (p_single) else $error("second request taken");

  // Clear stays released while transfers complete.
  property p_clear_high;
    @(posedge clk) disable iff (sys_rst) req_done |-> clear_n;
  endproperty
  a_clear_high: assert property (p_clear_high) else $error("clear during run");

  // Counts how long the write strobe has been low, so that a stretch that is too long or
  // too short shows without unrolling a long repetition; it saturates rather than wraps.
  logic [LCSEL_CNT_W-1:0] low_run_r, low_run_nxt;
  always_comb begin
    low_run_nxt = '0;
    if (!sel_wr_n) begin
      low_run_nxt = (low_run_r == '1) ? low_run_r : low_run_r + 1'b1;
    end
  end

  // Registers only.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      low_run_r <= '0;
    end else begin
      low_run_r <= low_run_nxt;
    end
  end

  // The strobe never stays low past its pulse count.
  property p_low_run;
    @(posedge clk) disable iff (sys_rst)
      !sel_wr_n |-> low_run_r < LCSEL_CNT_W'(LCSEL_WR_PULSE_CYC);
  endproperty
  a_low_run: assert property (p_low_run) else $error("strobe low too long");

  // When the strobe rises it has been low for exactly the pulse count.
  property p_run_end;
    @(posedge clk) disable iff (sys_rst)
      $rose(sel_wr_n) |-> low_run_r == LCSEL_CNT_W'(LCSEL_WR_PULSE_CYC);
  endproperty
  a_run_end: assert property (p_run_end) else $error("strobe width wrong");

  // Ready comes back on the cycle after the done pulse.
  property p_ready_after_done;
    @(posedge clk) disable iff (sys_rst) req_done |=> req_ready;
  endproperty
  a_ready_after_done: assert property (p_ready_after_done) else $error("ready late");

  // No request can be taken while a strobe is under way.
  property p_busy_not_ready;
    @(posedge clk) disable iff (sys_rst) !sel_wr_n |-> !req_ready;
  endproperty
  a_busy_not_ready: assert property (p_busy_not_ready) else $error("ready while busy");

  // A taken request lands on the selector lines on the next cycle and drops ready.
  property p_take;
    @(posedge clk) disable iff (sys_rst) req_valid && req_ready |=>
      sel_addr == $past(req_chan) && sel_enable == $past(req_enable) && !req_ready;
  endproperty
  a_take: assert property (p_take) else $error("request not taken");

  // The one character of a transfer does not change while data valid is active.
  property p_char_hold;
    @(posedge clk) disable iff (sys_rst) !host_data_valid_out |-> $stable(character_bus);
  endproperty
  a_char_hold: assert property (p_char_hold) else $error("character moved");

  // A strobe only ever follows a request taken one cycle more than the setup time before it.
  property p_strobe_after_take;
    @(posedge clk) disable iff (sys_rst) $fell(sel_wr_n) |-> $past(start_r, SETUP_PAST);
  endproperty
  a_strobe_after_take: assert property (p_strobe_after_take) else $error("stray strobe");

  // Clear is only low straight after the host's own reset.
  property p_clear_reset;
    @(posedge clk) disable iff (sys_rst) !clear_n |-> $past(sys_rst);
  endproperty
  a_clear_reset: assert property (p_clear_reset) else $error("clear without reset");
endmodule
`default_nettype wire

// ---- tb/lcsel_sel_model.sv ----
// Behavioural model of the latched one-of-eight selector driven by the host.
`default_nettype none
module lcsel_sel_model
  import lcsel_pkg::*;
(
  input wire logic [2:0] sel_addr,
  input wire logic sel_enable,
  input wire logic sel_wr_n,
  input wire logic clear_n,
  input wire logic [7:0] character_bus,
  input wire logic host_data_valid_out,
  output logic [7:0] sw,
  output logic [2:0] char_lat
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] addr_lat;
  logic en_lat;
  // Address latches follow while the strobe is low and keep their value after it rises.
  always_latch begin
    if (!clear_n) begin
      addr_lat = 3'h0;
      en_lat = 1'b0;
    end else if (!sel_wr_n) begin
      addr_lat = sel_addr;
      en_lat = sel_enable;
    end
  end
  // Character latch follows the low three bits while data valid is active and keeps them after.
  always_latch begin
    if (!host_data_valid_out) begin
      char_lat = character_bus[2:0];
    end
  end
  // Exactly one switch closes for an enabled address, none otherwise.
  assign sw = en_lat ? (8'h01 << addr_lat) : 8'h00;
endmodule
`default_nettype wire

// ---- tb/latched_channel_select_tb.sv ----
// Self-checking bench for the host controller against the selector model.
`default_nettype none
module latched_channel_select_tb
  import lcsel_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic req_valid = 1'b0;
  logic [2:0] req_chan = 3'h0;
  logic req_enable = 1'b0;
  logic req_ready, req_done, host_data_valid_out, host_data_accepted_in;
  logic sel_enable, sel_wr_n, clear_n;
  logic [7:0] character_bus, sw;
  logic [2:0] sel_addr, char_lat;
  int fails = 0;
  int checks = 0;
  int cyc = 0;
  lcsel_host lcsel_host_i (.clk(clk), .sys_rst(sys_rst), .req_valid(req_valid),
    .req_chan(req_chan), .req_enable(req_enable), .req_ready(req_ready),
    .req_done(req_done), .character_bus(character_bus),
    .host_data_valid_out(host_data_valid_out),
    .host_data_accepted_in(host_data_accepted_in), .sel_addr(sel_addr),
    .sel_enable(sel_enable), .sel_wr_n(sel_wr_n), .clear_n(clear_n));
  lcsel_sel_model lcsel_sel_model_i (.sel_addr(sel_addr), .sel_enable(sel_enable),
    .sel_wr_n(sel_wr_n), .clear_n(clear_n), .character_bus(character_bus),
    .host_data_valid_out(host_data_valid_out), .sw(sw), .char_lat(char_lat));
  // Clock at 50 MHz.
  always #10 clk = ~clk;
  // Cuts a hang short.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      final_report();
    end
  end
  // Compares one value and reports a mismatch.
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One channel select transfer, timed from the taking edge.
  task automatic xfer(input logic [2:0] c, input logic e);
    int n;
    int lo;
    n = 0;
    lo = 0;
    while (req_ready !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    req_valid = 1'b1;
    req_chan = c;
    req_enable = e;
    @(posedge clk);
    #1;
    req_valid = 1'b0;
    req_chan = ~c;
    while (req_done !== 1'b1 && n < 60) begin
      if (sel_wr_n === 1'b0) lo++;
      @(posedge clk);
      #1;
      n++;
    end
    chk("done_delay", 3 + LCSEL_SETUP_CYC + LCSEL_WR_PULSE_CYC, n);
    chk("strobe_width", LCSEL_WR_PULSE_CYC, lo);
    chk("accepted_in", 1'b0, host_data_accepted_in);
    chk("switches", e ? (8'h01 << c) : 8'h00, sw);
    chk("char_bus", LCSEL_DIGIT_ZERO | c, character_bus);
    chk("char_latch", c, char_lat);
  endtask
  // Every channel enabled, back to back.
  task automatic t_sweep();
    for (int c = 0; c < 8; c++) xfer(3'(c), 1'b1);
    $display("t_sweep done");
  endtask
  // Enable low leaves every switch open.
  task automatic t_disable();
    xfer(3'h5, 1'b0);
    $display("t_disable done");
  endtask
  // Reset after a finished transfer clears the selector at once.
  task automatic t_clear();
    xfer(3'h6, 1'b1);
    sys_rst = 1'b1;
    #1;
    chk("clear_n", 1'b0, clear_n);
    chk("switches_clr", 8'h00, sw);
    repeat (6) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    xfer(3'h7, 1'b1);
    $display("t_clear done");
  endtask
  // Prints the counts and the verdict.
  task automatic final_report();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Main sequence.
  initial begin
    repeat (6) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    t_sweep();
    t_disable();
    t_clear();
    final_report();
  end
endmodule
`default_nettype wire
